// file: design/shift_rotate_pkg.sv
package shift_rotate_pkg;

    // First opcode byte patterns, bit 0 is the width select
    localparam logic [6:0] OPC_COUNT_ONE  = 7'h68;
    localparam logic [6:0] OPC_COUNT_REG  = 7'h69;
    localparam logic [6:0] OPC_COUNT_IMM  = 7'h60;

    // Operation field of the second byte, bits 5..3
    localparam logic [2:0] OP_ROTATE_LEFT                = 3'h0;
    localparam logic [2:0] OP_ROTATE_RIGHT               = 3'h1;
    localparam logic [2:0] OP_ROTATE_LEFT_THROUGH_CARRY  = 3'h2;
    localparam logic [2:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 3'h3;
    localparam logic [2:0] OP_LOGICAL_RIGHT_SHIFT        = 3'h5;
    localparam logic [2:0] OP_ARITHMETIC_RIGHT_SHIFT     = 3'h7;
    localparam int         OP_LSB  = 3;
    localparam int         MODE_LSB = 6;
    localparam logic [1:0] MODE_REG = 2'h3;

    // Clock costs
    localparam int CYC_ONE_REG   = 6;
    localparam int CYC_ONE_MEM8  = 13;
    localparam int CYC_ONE_MEM16 = 21;
    localparam int CYC_CNT_REG   = 7;
    localparam int CYC_CNT_MEM8  = 16;
    localparam int CYC_CNT_MEM16 = 24;
    localparam int CYC_W         = 10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STEP = 2'b01,
        ST_WAIT = 2'b11
    } state_t;

endpackage : shift_rotate_pkg

// file: design/shift_rotate_unit.sv
`timescale 1ns/1ps
// Contract
// - One-bit logical right: carry takes LSB, shift right, zero in top.
// - Logical right one-bit overflow is top bit xor next bit.
// - Count-register forms load counter, repeat step, decrement to zero.
// - Immediate forms load counter from imm8, repeat step to zero.
// - Arithmetic right keeps the sign bit in place each step.
// - Rotate left: carry and LSB take old top bit.
// - Rotate left one-bit overflow is top bit xor new carry.
// - Rotate right: carry takes LSB, new carry goes to top.
// - Rotate right one-bit overflow is xor of top two bits.
// - Rotate right through carry: old carry enters at top.
// - First byte 1101000W count one, 1101001W register, 1100000W imm.
// - Second byte bits 5..3 select the operation.
// - Mode bits 11 mean register operand, else memory.
// - Cycles 6, 13/21, 7+n, 16/24+n by form and width.
module shift_rotate_unit
    import shift_rotate_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic [7:0]  opcode1,
    input  wire logic [7:0]  opcode2,
    input  wire logic [7:0]  imm8,
    input  wire logic [7:0]  count_register,
    input  wire logic [15:0] operand,
    input  wire logic        carry_flag_in,
    input  wire logic        overflow_in,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic [15:0]      result,
    output logic             carry_flag,
    output logic             overflow_flag,
    output logic             mem_operand
);
    state_t      state_reg,   state_next;
    logic [15:0] value_reg,   value_next;
    logic        carry_reg,   carry_next;
    logic        ovf_reg,     ovf_next;
    logic [7:0]  count_reg,   count_next;
    logic [8:0]  wait_reg,    wait_next;
    logic [2:0]  op_reg,      op_next;
    logic        word_reg,    word_next;
    logic        single_reg,  single_next;
    logic        done_reg,    done_next;
    logic        ill_reg,     ill_next;
    logic        mem_reg,     mem_next;
    logic        busy_reg,    busy_next;

    logic [15:0] step_value;
    logic        step_carry;
    logic        step_ovf;

    shift_step u_step (
        .op        (op_reg),
        .word      (word_reg),
        .value     (value_reg),
        .carry_in  (carry_reg),
        .result    (step_value),
        .carry_out (step_carry),
        .overflow  (step_ovf)
    );

    function automatic logic op_legal(input logic [2:0] op);
        op_legal = (op != 3'h4) && (op != 3'h6);
    endfunction : op_legal

    // Fixed overhead beyond the n step cycles, minus one done cycle
    function automatic logic [8:0] overhead(input logic one, input logic mem,
                                            input logic word);
        int c;
        if (one)
            c = mem ? (word ? CYC_ONE_MEM16 : CYC_ONE_MEM8) : CYC_ONE_REG;
        else
            c = mem ? (word ? CYC_CNT_MEM16 : CYC_CNT_MEM8) : CYC_CNT_REG;
        overhead = 9'(c - 1);
    endfunction : overhead

    logic [1:0] form;
    logic       is_mem;
    logic [7:0] load_count;

    always_comb begin
        state_next  = state_reg;
        value_next  = value_reg;
        carry_next  = carry_reg;
        ovf_next    = ovf_reg;
        count_next  = count_reg;
        wait_next   = wait_reg;
        op_next     = op_reg;
        word_next   = word_reg;
        single_next = single_reg;
        ill_next    = ill_reg;
        mem_next    = mem_reg;
        done_next   = 1'b0;
        form        = 2'h3;
        if (opcode1[7:1] == OPC_COUNT_ONE) form = 2'h0;
        else if (opcode1[7:1] == OPC_COUNT_REG) form = 2'h1;
        else if (opcode1[7:1] == OPC_COUNT_IMM) form = 2'h2;
        is_mem     = opcode2[7:MODE_LSB] != MODE_REG;
        load_count = (form == 2'h1) ? count_register
                   : (form == 2'h2) ? imm8 : 8'h01;
        unique case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    op_next    = opcode2[OP_LSB+2:OP_LSB];
                    word_next  = opcode1[0];
                    mem_next   = is_mem;
                    value_next = opcode1[0] ? operand
                                            : {8'h00, operand[7:0]};
                    carry_next = carry_flag_in;
                    ovf_next   = overflow_in;
                    if (form == 2'h3 || !op_legal(opcode2[5:3])) begin
                        ill_next  = 1'b1;
                        done_next = 1'b1;
                    end else begin
                        ill_next    = 1'b0;
                        single_next = (form == 2'h0);
                        count_next  = load_count;
                        wait_next   = overhead(form == 2'h0, is_mem,
                                               opcode1[0]);
                        state_next  = ST_STEP;
                    end
                end
            end
            ST_STEP: begin
                if (count_reg != 8'h00) begin
                    value_next = step_value;
                    carry_next = step_carry;
                    if (single_reg) ovf_next = step_ovf;
                    count_next = count_reg - 8'h01;
                end
                // Counted steps add to the overhead, a lone or empty one not
                if (single_reg || count_reg == 8'h00)
                    wait_next = wait_reg - 9'h001;
                if (count_reg <= 8'h01) state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (wait_reg <= 9'h001) begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    wait_next = wait_reg - 9'h001;
                end
            end
        endcase
        busy_next = state_next != ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            value_reg  <= 16'h0000;
            carry_reg  <= 1'b0;
            ovf_reg    <= 1'b0;
            count_reg  <= 8'h00;
            wait_reg   <= 9'h000;
            op_reg     <= 3'h0;
            word_reg   <= 1'b0;
            single_reg <= 1'b0;
            done_reg   <= 1'b0;
            ill_reg    <= 1'b0;
            mem_reg    <= 1'b0;
            busy_reg   <= 1'b0;
        end else if (clk_en) begin
            state_reg  <= state_next;
            value_reg  <= value_next;
            carry_reg  <= carry_next;
            ovf_reg    <= ovf_next;
            count_reg  <= count_next;
            wait_reg   <= wait_next;
            op_reg     <= op_next;
            word_reg   <= word_next;
            single_reg <= single_next;
            done_reg   <= done_next;
            ill_reg    <= ill_next;
            mem_reg    <= mem_next;
            busy_reg   <= busy_next;
        end
    end

    always_comb begin
        busy          = busy_reg;
        done          = done_reg;
        illegal       = ill_reg;
        result        = value_reg;
        carry_flag    = carry_reg;
        overflow_flag = ovf_reg;
        mem_operand   = mem_reg;
    end

    property p_logical_carry;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP
         && op_reg == OP_LOGICAL_RIGHT_SHIFT && count_reg != 8'h00)
        |=> carry_reg == $past(value_reg[0]);
    endproperty
    a_logical_carry: assert property (p_logical_carry)
        else $error("shift right carry wrong");

    property p_zero_count;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && count_reg == 8'h00)
        |=> value_reg == $past(value_reg) && carry_reg == $past(carry_reg);
    endproperty
    a_zero_count: assert property (p_zero_count)
        else $error("zero count changed operand");

    property p_sign_kept;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && word_reg
         && op_reg == OP_ARITHMETIC_RIGHT_SHIFT)
        |=> value_reg[15] == $past(value_reg[15]);
    endproperty
    a_sign_kept: assert property (p_sign_kept)
        else $error("sign bit not kept");

    property p_rotate_left;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && op_reg == OP_ROTATE_LEFT
         && word_reg
         && count_reg != 8'h00)
        |=> carry_reg == $past(value_reg[15])
            && value_reg[0] == $past(value_reg[15]);
    endproperty
    a_rotate_left: assert property (p_rotate_left)
        else $error("rotate left wrong");

    property p_rotate_right_carry;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && word_reg
         && op_reg == OP_ROTATE_RIGHT_THROUGH_CARRY
         && count_reg != 8'h00)
        |=> value_reg[15] == $past(carry_reg)
            && carry_reg == $past(value_reg[0]);
    endproperty
    a_rotate_right_carry: assert property (p_rotate_right_carry)
        else $error("rotate right through carry wrong");

    property p_rotate_left_carry;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP
         && op_reg == OP_ROTATE_LEFT_THROUGH_CARRY
         && count_reg != 8'h00)
        |=> value_reg[0] == $past(carry_reg);
    endproperty
    a_rotate_left_carry: assert property (p_rotate_left_carry)
        else $error("rotate left through carry wrong");

    property p_count_dec;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && count_reg > 8'h01)
        |=> count_reg == $past(count_reg) - 8'h01 && state_reg == ST_STEP;
    endproperty
    a_count_dec: assert property (p_count_dec)
        else $error("counter not decremented");

    property p_one_reg_time;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && start && state_reg == ST_IDLE
         && opcode1[7:1] == OPC_COUNT_ONE && opcode2[7:6] == MODE_REG
         && op_legal(opcode2[5:3]))
        ##1 clk_en [*5] |=> done;
    endproperty
    a_one_reg_time: assert property (p_one_reg_time)
        else $error("one-bit register form timing wrong");

    property p_logical_ovf;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_reg == ST_STEP && single_reg && word_reg
         && op_reg == OP_LOGICAL_RIGHT_SHIFT)
        |=> overflow_flag == (value_reg[15] ^ value_reg[14]);
    endproperty
    a_logical_ovf: assert property (p_logical_ovf)
        else $error("shift right overflow wrong");
endmodule : shift_rotate_unit

// file: design/shift_step.sv
`timescale 1ns/1ps
module shift_step
    import shift_rotate_pkg::*;
(
    input  wire logic [2:0]  op,
    input  wire logic        word,
    input  wire logic [15:0] value,
    input  wire logic        carry_in,
    output logic      [15:0] result,
    output logic             carry_out,
    output logic             overflow
);
    logic msb;
    logic lsb;
    logic top;
    logic below;

    always_comb begin
        msb       = word ? value[15] : value[7];
        lsb       = value[0];
        result    = value;
        carry_out = carry_in;
        unique case (op)
            OP_LOGICAL_RIGHT_SHIFT: begin
                carry_out = lsb;
                result    = value >> 1;
            end
            OP_ARITHMETIC_RIGHT_SHIFT: begin
                carry_out = lsb;
                result    = value >> 1;
                if (word) result[15] = msb;
                else result[7] = msb;
            end
            OP_ROTATE_LEFT: begin
                carry_out = msb;
                result    = {value[14:0], msb};
            end
            OP_ROTATE_RIGHT: begin
                carry_out = lsb;
                result    = value >> 1;
                if (word) result[15] = lsb;
                else result[7] = lsb;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                carry_out = msb;
                result    = {value[14:0], carry_in};
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                carry_out = lsb;
                result    = value >> 1;
                if (word) result[15] = carry_in;
                else result[7] = carry_in;
            end
            default: begin
                result    = value;
                carry_out = carry_in;
            end
        endcase
        if (!word) result[15:8] = 8'h00;
        top   = word ? result[15] : result[7];
        below = word ? result[14] : result[6];
        unique case (op)
            OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_RIGHT,
            OP_ROTATE_RIGHT_THROUGH_CARRY:
                overflow = top ^ below;
            OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY:
                overflow = top ^ carry_out;
            default:
                overflow = 1'b0;
        endcase
    end
endmodule : shift_step

// file: verification/shift_rotate_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
    err_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module shift_rotate_unit_tb_top;
    import shift_rotate_pkg::*;

    logic        sys_clk        = 1'b0;
    logic        rst            = 1'b1;
    logic        clk_en         = 1'b1;
    logic        start          = 1'b0;
    logic [7:0]  opcode1        = 8'h00;
    logic [7:0]  opcode2        = 8'h00;
    logic [7:0]  imm8           = 8'h00;
    logic [7:0]  count_register = 8'h00;
    logic [15:0] operand        = 16'h0000;
    logic        carry_flag_in  = 1'b0;
    logic        overflow_in    = 1'b0;
    logic        busy;
    logic        done;
    logic        illegal;
    logic [15:0] result;
    logic        carry_flag;
    logic        overflow_flag;
    logic        mem_operand;
    int          err_count      = 0;
    int          checks         = 0;
    logic [2:0]  ops [6]        = '{OP_LOGICAL_RIGHT_SHIFT,
                                    OP_ARITHMETIC_RIGHT_SHIFT,
                                    OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
                                    OP_ROTATE_LEFT_THROUGH_CARRY,
                                    OP_ROTATE_RIGHT_THROUGH_CARRY};

    always #12.5 sys_clk = ~sys_clk;

    shift_rotate_unit uut (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .clk_en         (clk_en),
        .start          (start),
        .opcode1        (opcode1),
        .opcode2        (opcode2),
        .imm8           (imm8),
        .count_register (count_register),
        .operand        (operand),
        .carry_flag_in  (carry_flag_in),
        .overflow_in    (overflow_in),
        .busy           (busy),
        .done           (done),
        .illegal        (illegal),
        .result         (result),
        .carry_flag     (carry_flag),
        .overflow_flag  (overflow_flag),
        .mem_operand    (mem_operand)
    );

    // Reference: {carry, overflow, result}
    function automatic logic [17:0] model(input logic [2:0] op,
        input logic w, input logic one, input logic [7:0] n,
        input logic [15:0] v, input logic c, input logic ov);
        logic [15:0] x;
        logic        nc;
        int          top;
        x = w ? v : {8'h00, v[7:0]};
        top = w ? 15 : 7;
        for (int i = 0; i < int'(n); i++) begin
            nc = (op == OP_ROTATE_LEFT || op == OP_ROTATE_LEFT_THROUGH_CARRY)
                 ? x[top] : x[0];
            case (op)
                OP_ROTATE_LEFT:
                    x = (x << 1) | {15'h0000, nc};
                OP_ROTATE_LEFT_THROUGH_CARRY:
                    x = (x << 1) | {15'h0000, c};
                OP_ROTATE_RIGHT: begin
                    x = x >> 1;
                    x[top] = nc;
                end
                OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                    x = x >> 1;
                    x[top] = c;
                end
                OP_ARITHMETIC_RIGHT_SHIFT: begin
                    x = x >> 1;
                    x[top] = x[top-1];
                end
                default: x = x >> 1;
            endcase
            if (!w) x[15:8] = 8'h00;
            c = nc;
        end
        if (one) begin
            case (op)
                OP_ARITHMETIC_RIGHT_SHIFT: ov = 1'b0;
                OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY:
                    ov = x[top] ^ c;
                default:          ov = x[top] ^ x[top-1];
            endcase
        end
        return {c, ov, x};
    endfunction : model

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // One operation from issue to done, with optional clock-enable stall
    task automatic run(input logic [7:0] op1, input logic [7:0] op2,
        input logic [7:0] n, input logic [15:0] v, input logic c,
        input logic stall);
        logic [17:0] exp;
        logic        one;
        logic        cnt_reg;
        logic        mem;
        logic        bad;
        int          cyc;
        int          cnt;
        one = op1[7:1] == OPC_COUNT_ONE;
        cnt_reg = op1[7:1] == OPC_COUNT_REG;
        mem = op2[7:6] != MODE_REG;
        bad = !(one || cnt_reg || op1[7:1] == OPC_COUNT_IMM)
            || op2[5:3] == 3'h4 || op2[5:3] == 3'h6;
        exp = bad ? {c, c ^ v[3], op1[0] ? v : {8'h00, v[7:0]}}
            : model(op2[5:3], op1[0], one, one ? 8'h01 : n, v, c, c ^ v[3]);
        if (one) cyc = mem ? (op1[0] ? CYC_ONE_MEM16 : CYC_ONE_MEM8)
                           : CYC_ONE_REG;
        else cyc = (mem ? (op1[0] ? CYC_CNT_MEM16 : CYC_CNT_MEM8)
                        : CYC_CNT_REG) + int'(n);
        @(posedge sys_clk);
        start <= 1'b1;
        opcode1 <= op1;
        opcode2 <= op2;
        count_register <= cnt_reg ? n : ~n;
        imm8 <= cnt_reg ? ~n : n;
        operand <= v;
        carry_flag_in <= c;
        overflow_in <= c ^ v[3];
        @(posedge sys_clk);
        start <= 1'b0;
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
            if (stall) clk_en <= !(cnt >= 2 && cnt < 5);
            if (cnt == 1 && !bad) `CHK("busy", 1'b1, busy)
        end while (done !== 1'b1 && cnt < 300);
        if (cnt >= 300) begin
            err_count++;
            $display("Error done expected 1 seen 0");
            print_verdict();
        end
        if (!bad) `CHK("cycles", cyc + (stall ? 3 : 0), cnt)
        `CHK("busy", 1'b0, busy)
        `CHK("illegal", bad, illegal)
        `CHK("result", exp[15:0], result)
        `CHK("carry_flag", exp[17], carry_flag)
        `CHK("overflow_flag", exp[16], overflow_flag)
        if (!bad) `CHK("mem_operand", mem, mem_operand)
    endtask : run

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (ops[i]) begin
            for (int w = 0; w < 2; w++) begin
                for (int f = 0; f < 3; f++) begin
                    run({f == 0 ? OPC_COUNT_ONE : f == 1 ? OPC_COUNT_REG
                        : OPC_COUNT_IMM, w[0]}, {MODE_REG, ops[i], 3'h0},
                        8'(3 + 2 * f), 16'hA5C3 ^ 16'(i * 16'h1111),
                        i[0], 1'b0);
                end
            end
        end
        $display("Test operations finished");
        run({OPC_COUNT_ONE, 1'b0}, {2'h0, OP_LOGICAL_RIGHT_SHIFT, 3'h6},
            8'h00, 16'h00F1, 1'b1, 1'b0);
        run({OPC_COUNT_ONE, 1'b1}, {2'h1, OP_ROTATE_LEFT, 3'h2},
            8'h00, 16'h4001, 1'b0, 1'b0);
        run({OPC_COUNT_IMM, 1'b1}, {2'h2, OP_ARITHMETIC_RIGHT_SHIFT, 3'h0},
            8'h04, 16'h8001, 1'b0, 1'b0);
        run({OPC_COUNT_REG, 1'b0},
            {2'h0, OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h5},
            8'h02, 16'h0003, 1'b1, 1'b0);
        $display("Test memory forms finished");
        run({OPC_COUNT_REG, 1'b1}, {MODE_REG, OP_ROTATE_LEFT, 3'h0},
            8'h00, 16'h1234, 1'b1, 1'b0);
        run({OPC_COUNT_IMM, 1'b0}, {MODE_REG, OP_LOGICAL_RIGHT_SHIFT, 3'h1},
            8'h00, 16'h00FF, 1'b0, 1'b0);
        run({OPC_COUNT_IMM, 1'b1},
            {MODE_REG, OP_ROTATE_LEFT_THROUGH_CARRY, 3'h0},
            8'h11, 16'hF00D, 1'b1, 1'b0);
        run({OPC_COUNT_REG, 1'b0},
            {MODE_REG, OP_ARITHMETIC_RIGHT_SHIFT, 3'h0},
            8'h09, 16'h0080, 1'b0, 1'b0);
        $display("Test counts finished");
        run({OPC_COUNT_REG, 1'b1}, {MODE_REG, OP_ROTATE_RIGHT, 3'h0},
            8'h03, 16'h0F0F, 1'b0, 1'b1);
        $display("Test stall finished");
        run({OPC_COUNT_ONE, 1'b1}, {MODE_REG, 3'h4, 3'h0}, 8'h00,
            16'h5A5A, 1'b1, 1'b0);
        run({OPC_COUNT_ONE, 1'b1}, {MODE_REG, 3'h6, 3'h0}, 8'h00,
            16'h5A5A, 1'b0, 1'b0);
        run(8'hC4, {MODE_REG, OP_ROTATE_LEFT, 3'h0}, 8'h02,
            16'h1357, 1'b1, 1'b0);
        $display("Test illegal finished");
        print_verdict();
    end

endmodule : shift_rotate_unit_tb_top
